// ---- rtl/sfs_pkg.sv ----
/*
 * Constants for the sensor front-end serial slave: command bit positions,
 * control-vector layout, reset values, frame length and timing counts.
 * Assumes a 20 MHz core clock; all users refer to names as sfs_pkg::name.
 */
package sfs_pkg;

	// Frame geometry
	localparam int FRAME_BITS = 64;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	localparam logic [CNT_W-1:0] CNT_FRAME = 12'h040;
	localparam logic [2:0] CHAIN_STEP_MASK = 3'h7;

	// Command word bit positions
	localparam int BIT_OUT_SEL = 59;
	localparam int BIT_CTL_HI = 58;
	localparam int BIT_CTL_LO = 51;
	localparam int BIT_FAULT_CLEAR = 47;
	localparam int BIT_CONFIRM_HIGH = 15;
	localparam int BIT_CONFIRM_LOW = 14;

	// Control vector, command bits 58..51 in order
	localparam int CTL_W = 8;
	localparam int CTL_REF_PD = 7;
	localparam int CTL_REF_DIAG = 6;
	localparam int CTL_REF_GAIN = 5;
	localparam int CTL_PUMP_SW = 4;
	localparam int CTL_PUMP_SRC = 3;
	localparam int CTL_PUMP_CHAN = 2;
	localparam int CTL_PUMP_PD = 1;
	localparam int CTL_COMP = 0;
	localparam logic [CTL_W-1:0] CTL_RESET = 8'h02;
	localparam logic OUT_SEL_RESET = 1'h0;
	localparam logic FLAG_A_RESET = 1'h0;
	localparam logic FLAG_B_RESET = 1'h1;

	// Timing
	localparam int CORE_PERIOD_NS = 50;
	localparam int CS_GLITCH_NS = 50;
	localparam int CS_GLITCH_CYC = (CS_GLITCH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int SEQ_DELAY_NS = 1000;
	localparam int SEQ_DELAY_CYC_RAW = (SEQ_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int SEQ_DELAY_CYC = (SEQ_DELAY_CYC_RAW < 1) ? 1 : SEQ_DELAY_CYC_RAW;
	localparam int SEQ_W = 8;
	localparam int SEL_W = 4;

	// Sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'h1,
		SEQ_WAIT = 3'h2,
		SEQ_LAST = 3'h4
	} sfs_seq_t;

endpackage : sfs_pkg

// ---- rtl/sfs_spi_slave.sv ----
/*
 * Serial command slave of the sensor front end: link-clocked shift path,
 * core-clocked frame checking, fault flags, deferred and sequenced controls.
 * Assumes the master leaves at least three core cycles between chip select
 * falling and the first serial clock edge, and that the serial clock is
 * still outside frames. A measurement-cycle start pulse comes from core logic.
 * The shift register and bit count reach the core unsynchronised; they are
 * stable because the core reads them only after select is high and clocks stop.
 * Limitation: a clockless frame before the first clocked one goes unflagged.
 */
// Behaviour
// R01 - Slave; extra clocks pass input to output
// R02 - Send 64 output bits, then received bits
// R03 - Select loads status, one bit per clock
// R04 - Deselected: output released, status reloaded
// R05 - Select pulses up to 50 ns ignored
// R06 - Sample and shift on rising clock edge
// R07 - Master sends 64 bits MSB first
// R08 - Command bits 63 to 60 ignored
// R09 - Bit 59 picks status or command echo
// R10 - Control changes wait for next cycle; diagnostic enable (bit 57) applies when the frame is accepted
// R11 - Channel and network changes also deferred
// R12 - Sequence reference pulldown against pump enable
// R13 - Sequence pump pulldown against pump enable
// R14 - Bits 58, 57: pulldown and diagnostic enables
// R15 - Bit 56 selects amplifier gain
// R16 - Bit 55 closes pump switches
// R17 - Bit 54 enables pump source, else parking
// R18 - Bit 53 selects pump channel
// R19 - Bit 51 selects compensation network
// R20 - Bit 52 pump pulldown, resets to one
// R21 - Other control bits reset to zero
// R22 - Reject pulldown together with pump enable
// R23 - Bad confirmation bits: discard, flag, deselect echo
// R24 - Length not 64 plus 8n is fault
// R25 - Fault clear acts at select release
// R26 - Echo is last accepted frame, same order
`timescale 1ns/1ns
module sfs_spi_slave #(
	parameter int SEQ_DELAY = sfs_pkg::SEQ_DELAY_CYC
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Serial link pins
	input wire logic spi_sclk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Core side
	input wire logic [63:0] status_word,
	input wire logic meas_cycle_start,
	// Applied controls
	output logic ref_cell_pulldown_en,
	output logic ref_cell_gnd_diag_en,
	output logic ref_amp_gain_sel,
	output logic pump_switch_en,
	output logic pump_source_en,
	output logic pump_channel_sel,
	output logic pump_pulldown_en,
	output logic comp_network_sel,
	// Fault state
	output logic serial_fault_flag_a,
	output logic serial_fault_flag_b,
	output logic fault_clear_pulse,
	output logic out_select
);

	// Link domain
	logic armed_q;
	logic [63:0] shift_q;
	logic [sfs_pkg::CNT_W-1:0] bit_cnt_q;
	logic serial_out_q;
	logic frame_tog_q;

	// Core domain
	logic [1:0] cs_sync_q;
	logic cs_hi_prev_q;
	logic [sfs_pkg::SEL_W-1:0] sel_cnt_q;
	logic frame_seen_q;
	logic [1:0] tog_sync_q;
	logic tog_seen_q;
	logic oe_q;
	logic [63:0] tx_q;
	logic [63:0] echo_q;
	logic out_sel_q;
	logic flag_a_q;
	logic flag_b_q;
	logic clear_q;
	logic [sfs_pkg::CTL_W-1:0] pend_q;
	logic pend_valid_q;
	logic [sfs_pkg::CTL_W-1:0] appl_q;
	logic [sfs_pkg::CTL_W-1:0] final_q;
	logic [sfs_pkg::SEQ_W-1:0] seq_cnt_q;
	sfs_pkg::sfs_seq_t seq_q;

	logic cs_rise;
	logic frame_end;
	logic len_bad;
	logic confirm_bad;
	logic cmd_bad;
	logic accept;
	logic [63:0] rx;
	logic [sfs_pkg::CTL_W-1:0] rx_ctl;
	logic [sfs_pkg::CTL_W-1:0] stage1;
	logic need_seq;

	// Armed by select high; first clock edge of a frame clears it
	always_ff @(posedge spi_sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= 1'b0;
		end
	end

	// Shift path; tx_q is frozen by the core while selected
	always_ff @(posedge spi_sclk) begin
		if (armed_q) begin
			serial_out_q <= tx_q[63]; // R03
			shift_q <= {tx_q[62:0], serial_in}; // R06
			bit_cnt_q <= {{(sfs_pkg::CNT_W-1){1'b0}}, 1'b1};
			// Core acknowledge is quiet here, so no power-up value is needed
			frame_tog_q <= ~tog_seen_q;
		end else begin
			serial_out_q <= shift_q[63]; // R01 R02
			shift_q <= {shift_q[62:0], serial_in}; // R06
			// Saturating count keeps a very long chain a length fault
			if (bit_cnt_q != sfs_pkg::CNT_MAX) begin
				bit_cnt_q <= bit_cnt_q + {{(sfs_pkg::CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign serial_out = serial_out_q;
	assign serial_out_oe = oe_q;

	// Select synchroniser
	// The frame toggle is one bit, so two stages suffice
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cs_sync_q <= 2'h3;
			cs_hi_prev_q <= 1'b1;
			tog_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[0], chip_select_n};
			cs_hi_prev_q <= cs_sync_q[1];
			tog_sync_q <= {tog_sync_q[0], frame_tog_q};
		end
	end

	assign cs_rise = cs_sync_q[1] & ~cs_hi_prev_q;

	// A short select pulse may open the driver for a cycle; harmless
	// Output enable follows synchronised select
	always_ff @(posedge core_clk) begin
		if (srst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= ~cs_sync_q[1]; // R04
		end
	end

	// Low time qualifier; short pulses never count as a frame
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sel_cnt_q <= '0;
			frame_seen_q <= 1'b0;
		end else if (cs_sync_q[1]) begin
			sel_cnt_q <= '0;
			if (cs_rise) begin
				frame_seen_q <= 1'b0;
			end
		end else begin
			if (sel_cnt_q != {sfs_pkg::SEL_W{1'b1}}) begin
				sel_cnt_q <= sel_cnt_q + {{(sfs_pkg::SEL_W-1){1'b0}}, 1'b1};
			end
			// Two synchronised low cycles exceed the glitch width
			if (sel_cnt_q >= sfs_pkg::SEL_W'(sfs_pkg::CS_GLITCH_CYC)) begin
				frame_seen_q <= 1'b1; // R05
			end
		end
	end

	assign frame_end = cs_rise & frame_seen_q; // R05

	// Link words are static once select is high and the clock has stopped
	assign rx = shift_q;
	assign rx_ctl = rx[sfs_pkg::BIT_CTL_HI:sfs_pkg::BIT_CTL_LO];

	// No edge seen this frame means zero bits
	always_comb begin
		len_bad = 1'b0;
		if (tog_sync_q[1] == tog_seen_q) begin
			len_bad = 1'b1;
		end else if (bit_cnt_q < sfs_pkg::CNT_FRAME) begin
			len_bad = 1'b1;
		end else if ((bit_cnt_q[2:0] & sfs_pkg::CHAIN_STEP_MASK) != 3'h0) begin
			len_bad = 1'b1; // R24
		end
	end

	// Upper confirmation bit must be one, lower bit zero
	assign confirm_bad = ~rx[sfs_pkg::BIT_CONFIRM_HIGH] | rx[sfs_pkg::BIT_CONFIRM_LOW]; // R23

	// Pump-on frames must not carry a pulldown; no frame may move the routing while the pump is applied
	always_comb begin
		cmd_bad = 1'b0;
		if (rx_ctl[sfs_pkg::CTL_PUMP_SRC] & rx_ctl[sfs_pkg::CTL_REF_PD]) begin
			cmd_bad = 1'b1; // R22
		end
		if (rx_ctl[sfs_pkg::CTL_PUMP_SRC] & rx_ctl[sfs_pkg::CTL_PUMP_PD]) begin
			cmd_bad = 1'b1; // R22
		end
		// Routing is frozen while the pump source drives the cell
		if (appl_q[sfs_pkg::CTL_PUMP_SRC] &&
			((rx_ctl[sfs_pkg::CTL_PUMP_CHAN] != appl_q[sfs_pkg::CTL_PUMP_CHAN]) ||
			(rx_ctl[sfs_pkg::CTL_COMP] != appl_q[sfs_pkg::CTL_COMP]))) begin
			cmd_bad = 1'b1; // R11
		end
	end

	assign accept = frame_end & ~len_bad & ~confirm_bad & ~cmd_bad;

	// Acknowledge of the last frame toggle, echoed back to the link side
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tog_seen_q <= 1'b0;
		end else if (frame_end) begin
			tog_seen_q <= tog_sync_q[1];
		end
	end

	// Transmit register reload while deselected
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_q <= '0;
		end else if (cs_sync_q[1] && !cs_rise) begin
			tx_q <= out_sel_q ? echo_q : status_word; // R04 R09
		end
	end

	// Echo of the last accepted word, bits 63..60 kept as received
	always_ff @(posedge core_clk) begin
		if (srst) begin
			echo_q <= '0;
		end else if (accept) begin
			echo_q <= rx; // R26
		end
	end

	// Output select; any fault forces status
	always_ff @(posedge core_clk) begin
		if (srst) begin
			out_sel_q <= sfs_pkg::OUT_SEL_RESET; // R09
		end else if (accept) begin
			out_sel_q <= rx[sfs_pkg::BIT_OUT_SEL]; // R09
		end else if (frame_end) begin
			out_sel_q <= 1'b0; // R23
		end
	end

	// Fault flags; a discarded frame cannot clear, so set always wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag_a_q <= sfs_pkg::FLAG_A_RESET;
			flag_b_q <= sfs_pkg::FLAG_B_RESET;
			clear_q <= 1'b0;
		end else begin
			clear_q <= 1'b0;
			if (frame_end && !accept) begin
				flag_a_q <= 1'b1; // R22 R23 R24
				flag_b_q <= 1'b0; // R23
			end else if (accept && rx[sfs_pkg::BIT_FAULT_CLEAR]) begin
				flag_a_q <= sfs_pkg::FLAG_A_RESET; // R25
				flag_b_q <= sfs_pkg::FLAG_B_RESET; // R25
				// Lands at frame end, after select has returned high
				clear_q <= 1'b1; // R25
			end
		end
	end

	// Pending controls wait for the cycle boundary
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pend_q <= sfs_pkg::CTL_RESET; // R20 R21
			pend_valid_q <= 1'b0;
		end else if (accept) begin
			pend_q <= rx_ctl; // R08 R10 R11
			pend_valid_q <= 1'b1;
		end else if (meas_cycle_start && seq_q == sfs_pkg::SEQ_IDLE) begin
			// Start pulses during sequencing leave the word pending
			pend_valid_q <= 1'b0;
		end
	end

	// First step: pulldowns off before pump on, or pump off before pulldowns on
	always_comb begin
		stage1 = pend_q;
		need_seq = 1'b0;
		if (pend_q[sfs_pkg::CTL_PUMP_SRC] && !appl_q[sfs_pkg::CTL_PUMP_SRC]) begin
			stage1[sfs_pkg::CTL_PUMP_SRC] = 1'b0; // R12 R13
			need_seq = 1'b1;
		end else if (!pend_q[sfs_pkg::CTL_PUMP_SRC] && appl_q[sfs_pkg::CTL_PUMP_SRC] &&
			(pend_q[sfs_pkg::CTL_REF_PD] || pend_q[sfs_pkg::CTL_PUMP_PD])) begin
			stage1[sfs_pkg::CTL_REF_PD] = appl_q[sfs_pkg::CTL_REF_PD]; // R12
			stage1[sfs_pkg::CTL_PUMP_PD] = appl_q[sfs_pkg::CTL_PUMP_PD]; // R13
			need_seq = 1'b1;
		end
		stage1[sfs_pkg::CTL_REF_DIAG] = appl_q[sfs_pkg::CTL_REF_DIAG];
	end

	// Sequencer for the applied controls
	always_ff @(posedge core_clk) begin
		if (srst) begin
			seq_q <= sfs_pkg::SEQ_IDLE;
			seq_cnt_q <= '0;
			final_q <= sfs_pkg::CTL_RESET;
		end else begin
			unique case (seq_q)
				sfs_pkg::SEQ_IDLE: begin
					if (meas_cycle_start && pend_valid_q && need_seq) begin
						seq_q <= sfs_pkg::SEQ_WAIT; // R12 R13
						seq_cnt_q <= sfs_pkg::SEQ_W'(SEQ_DELAY - 1);
						final_q <= pend_q;
					end
				end
				sfs_pkg::SEQ_WAIT: begin
					// Gap between the two switching steps
					if (seq_cnt_q == '0) begin
						seq_q <= sfs_pkg::SEQ_LAST;
					end else begin
						seq_cnt_q <= seq_cnt_q - {{(sfs_pkg::SEQ_W-1){1'b0}}, 1'b1};
					end
				end
				sfs_pkg::SEQ_LAST: begin
					seq_q <= sfs_pkg::SEQ_IDLE;
				end
				default: begin
					seq_q <= sfs_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// Applied controls; diagnostic enable is not deferred
	always_ff @(posedge core_clk) begin
		if (srst) begin
			appl_q <= sfs_pkg::CTL_RESET; // R20 R21
		end else begin
			if (seq_q == sfs_pkg::SEQ_IDLE && meas_cycle_start && pend_valid_q) begin
				appl_q[sfs_pkg::CTL_W-1:0] <= need_seq ? stage1 : pend_q; // R10 R11
			end else if (seq_q == sfs_pkg::SEQ_LAST) begin
				appl_q <= final_q; // R12 R13
			end
			// Later assignment wins, so the diagnostic bit tracks the frame
			if (accept) begin
				appl_q[sfs_pkg::CTL_REF_DIAG] <= rx_ctl[sfs_pkg::CTL_REF_DIAG]; // R14
			end
		end
	end

	// All outputs come straight from registers
	assign ref_cell_pulldown_en = appl_q[sfs_pkg::CTL_REF_PD]; // R14
	assign ref_cell_gnd_diag_en = appl_q[sfs_pkg::CTL_REF_DIAG]; // R14
	assign ref_amp_gain_sel = appl_q[sfs_pkg::CTL_REF_GAIN]; // R15
	assign pump_switch_en = appl_q[sfs_pkg::CTL_PUMP_SW]; // R16
	assign pump_source_en = appl_q[sfs_pkg::CTL_PUMP_SRC]; // R17
	assign pump_channel_sel = appl_q[sfs_pkg::CTL_PUMP_CHAN]; // R18
	assign pump_pulldown_en = appl_q[sfs_pkg::CTL_PUMP_PD]; // R20
	assign comp_network_sel = appl_q[sfs_pkg::CTL_COMP]; // R19
	assign serial_fault_flag_a = flag_a_q;
	assign serial_fault_flag_b = flag_b_q;
	assign fault_clear_pulse = clear_q;
	assign out_select = out_sel_q;

endmodule : sfs_spi_slave

// ---- test/sfs_spi_slave_checker.sv ----
/*
 * Port checker for the sensor front-end serial slave.
 * Assumes one core clock domain with synchronous srst; bound to every instance.
 */
`timescale 1ns/1ns
module sfs_spi_slave_checker #(
	parameter int SEQ_DELAY = 2
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Inputs watched
	input wire logic chip_select_n,
	input wire logic meas_cycle_start,
	// Outputs watched
	input wire logic serial_out_oe,
	input wire logic ref_cell_pulldown_en,
	input wire logic ref_cell_gnd_diag_en,
	input wire logic ref_amp_gain_sel,
	input wire logic pump_switch_en,
	input wire logic pump_source_en,
	input wire logic pump_channel_sel,
	input wire logic pump_pulldown_en,
	input wire logic comp_network_sel,
	input wire logic serial_fault_flag_a,
	input wire logic serial_fault_flag_b,
	input wire logic fault_clear_pulse,
	input wire logic out_select
);
	wire logic [7:0] ctl = {ref_cell_pulldown_en, ref_cell_gnd_diag_en, ref_amp_gain_sel,
		pump_switch_en, pump_source_en, pump_channel_sel, pump_pulldown_en, comp_network_sel};
	wire logic [2:0] flg = {serial_fault_flag_a, serial_fault_flag_b, out_select};

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	a_oe_off: assert property (chip_select_n [*5] |-> !serial_out_oe)
		else $error("output enable high while deselected");
	a_oe_on: assert property ((!chip_select_n) [*5] |-> serial_out_oe)
		else $error("output enable low while selected");
	a_reset_vals: assert property (@(posedge core_clk) disable iff (1'b0) srst |=>
		ctl == 8'h02 && flg == 3'h2 && !serial_out_oe)
		else $error("wrong values after reset");
	a_pd_excl: assert property (!(pump_source_en && (ref_cell_pulldown_en || pump_pulldown_en)))
		else $error("pump on together with a pulldown");
	a_pump_wait: assert property ($rose(pump_source_en) |-> ($past(ctl, SEQ_DELAY) & 8'h8A) == 8'h00)
		else $error("pump enabled too soon after pulldown release");
	a_pd_wait: assert property (($rose(ref_cell_pulldown_en) || $rose(pump_pulldown_en))
		|-> !$past(pump_source_en, SEQ_DELAY))
		else $error("pulldown applied too soon after pump off");
	a_ctl_defer: assert property ($changed({ref_amp_gain_sel, pump_switch_en, pump_channel_sel,
		comp_network_sel}) |-> $past(meas_cycle_start) || $past(meas_cycle_start, 2))
		else $error("control changed outside a cycle start");
	a_fault_flags: assert property ($rose(serial_fault_flag_a) |-> flg == 3'h4)
		else $error("fault flag pair or output select wrong");
	a_flags_frame: assert property ($changed(flg) |-> $past(chip_select_n, 2))
		else $error("fault state changed while selected");
	a_clear_once: assert property (fault_clear_pulse |=> !fault_clear_pulse)
		else $error("fault clear pulse longer than one cycle");
endmodule : sfs_spi_slave_checker

bind sfs_spi_slave sfs_spi_slave_checker #(.SEQ_DELAY(SEQ_DELAY)) u_chk (
	.core_clk(core_clk),
	.srst(srst),
	.chip_select_n(chip_select_n),
	.meas_cycle_start(meas_cycle_start),
	.serial_out_oe(serial_out_oe),
	.ref_cell_pulldown_en(ref_cell_pulldown_en),
	.ref_cell_gnd_diag_en(ref_cell_gnd_diag_en),
	.ref_amp_gain_sel(ref_amp_gain_sel),
	.pump_switch_en(pump_switch_en),
	.pump_source_en(pump_source_en),
	.pump_channel_sel(pump_channel_sel),
	.pump_pulldown_en(pump_pulldown_en),
	.comp_network_sel(comp_network_sel),
	.serial_fault_flag_a(serial_fault_flag_a),
	.serial_fault_flag_b(serial_fault_flag_b),
	.fault_clear_pulse(fault_clear_pulse),
	.out_select(out_select)
);

// ---- test/sfs_host.sv ----
/*
 * Host-side serial master model: frames of up to 72 bits, MSB first.
 * Assumes the slave samples on the rising link clock; link period 32 ns.
 */
`timescale 1ns/1ns
module sfs_host (
	// Link pins
	output logic spi_sclk,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		spi_sclk = 1'h0;
		chip_select_n = 1'h0;
		serial_in = 1'h0;
		// Select rises after time zero so the link flops see a real edge
		#1 chip_select_n = 1'h1;
	end

	// Link clock stands still outside frames
	task automatic xfer(input logic [71:0] w, input int n, output logic [71:0] r);
		r = '0;
		chip_select_n = 1'h0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			#16 spi_sclk = 1'h1;
			#16 spi_sclk = 1'h0;
			r[i] = serial_out;
		end
		// Released line must not keep the last bit
		serial_in = ~serial_in;
		#16 chip_select_n = 1'h1;
		#400;
	endtask : xfer

	task automatic glitch();
		chip_select_n = 1'h0;
		#40 chip_select_n = 1'h1;
		#400;
	endtask : glitch
endmodule : sfs_host

// ---- test/tb.sv ----
/*
 * Self-checking bench for the serial slave, driven through the host model.
 * Assumes the checker is bound by its own file; sequencing delay shortened.
 */
`timescale 1ns/1ns
module tb;
	localparam int SD = 2;
	logic core_clk, srst, meas_cycle_start;
	logic [63:0] status_word;
	logic [71:0] rx;
	wire logic spi_sclk, chip_select_n, serial_in, serial_out, serial_out_oe;
	wire logic ref_cell_pulldown_en, ref_cell_gnd_diag_en, ref_amp_gain_sel, pump_switch_en;
	wire logic pump_source_en, pump_channel_sel, pump_pulldown_en, comp_network_sel;
	wire logic serial_fault_flag_a, serial_fault_flag_b, fault_clear_pulse, out_select;
	wire logic [7:0] ctl = {ref_cell_pulldown_en, ref_cell_gnd_diag_en, ref_amp_gain_sel,
		pump_switch_en, pump_source_en, pump_channel_sel, pump_pulldown_en, comp_network_sel};
	wire logic [1:0] flg = {serial_fault_flag_a, serial_fault_flag_b};
	int mismatches = 0;
	int n_tests = 0;
	int n_clr = 0;

	sfs_spi_slave #(.SEQ_DELAY(SD)) u_dut (
		.core_clk(core_clk),
		.srst(srst),
		.spi_sclk(spi_sclk),
		.chip_select_n(chip_select_n),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.status_word(status_word),
		.meas_cycle_start(meas_cycle_start),
		.ref_cell_pulldown_en(ref_cell_pulldown_en),
		.ref_cell_gnd_diag_en(ref_cell_gnd_diag_en),
		.ref_amp_gain_sel(ref_amp_gain_sel),
		.pump_switch_en(pump_switch_en),
		.pump_source_en(pump_source_en),
		.pump_channel_sel(pump_channel_sel),
		.pump_pulldown_en(pump_pulldown_en),
		.comp_network_sel(comp_network_sel),
		.serial_fault_flag_a(serial_fault_flag_a),
		.serial_fault_flag_b(serial_fault_flag_b),
		.fault_clear_pulse(fault_clear_pulse),
		.out_select(out_select)
	);
	sfs_host u_host (
		.spi_sclk(spi_sclk),
		.chip_select_n(chip_select_n),
		.serial_in(serial_in),
		.serial_out(serial_out)
	);

	// Clear pulse stands one cycle; counted away from the edge that launches it
	always @(negedge core_clk) begin
		if (fault_clear_pulse === 1'h1) begin
			n_clr++;
		end
	end

	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	function automatic logic [63:0] cmd(input logic sel, input logic [7:0] c, input logic clr);
		return {4'hF, sel, c, 3'h0, clr, 31'h0, 2'h2, 14'h0};
	endfunction : cmd

	task automatic frm(input logic [71:0] w, input int n);
		@(posedge core_clk);
		#5 u_host.xfer(w, n, rx);
	endtask : frm

	task automatic pulse();
		@(posedge core_clk);
		#5 meas_cycle_start = 1'h1;
		@(posedge core_clk);
		#5 meas_cycle_start = 1'h0;
		@(posedge core_clk);
		#5;
	endtask : pulse

	task automatic settle();
		repeat (SD + 1) @(posedge core_clk);
		#5;
	endtask : settle

	task automatic s_reset();
		chk("ctl", ctl, 8'h02);
		chk("state", {flg, out_select, serial_out_oe}, 4'h4);
	endtask : s_reset

	task automatic s_defer();
		frm(cmd(1'h1, 8'h79, 1'h0), 64);
		chk("status", rx[63:0], status_word);
		chk("early", ctl, 8'h42);
		chk("sel", {flg, out_select}, 3'h3);
		pulse();
		chk("stage", ctl, 8'h71);
		settle();
		chk("final", ctl, 8'h79);
	endtask : s_defer

	task automatic s_echo();
		frm({8'h3C, cmd(1'h0, 8'h79, 1'h0)}, 72);
		chk("echo", rx[71:8], cmd(1'h1, 8'h79, 1'h0));
		chk("chain", rx[7:0], 8'h3C);
		chk("sel", out_select, 1'h0);
	endtask : s_echo

	task automatic s_faults();
		logic [7:0] bc [4] = '{8'h79, 8'h7D, 8'hF9, 8'h7B};
		frm(cmd(1'h1, 8'h79, 1'h1) ^ 64'h8000, 64);
		chk("cfm", {flg, out_select}, 3'h4);
		u_host.glitch();
		chk("glitch", {flg, out_select}, 3'h4);
		@(posedge core_clk);
		#5 status_word = ~status_word;
		frm(cmd(1'h0, 8'h79, 1'h1), 64);
		chk("reload", rx[63:0], status_word);
		chk("clr", flg, 2'h1);
		for (int i = 0; i < 4; i++) begin
			frm(cmd(1'h0, bc[i], 1'h0), (i != 0) ? 64 : 63);
			chk("bad", flg, 2'h2);
			frm(cmd(1'h0, 8'h79, 1'h1), 64);
			chk("clr", flg, 2'h1);
		end
		pulse();
		settle();
		chk("kept", ctl, 8'h79);
		chk("clr_n", n_clr, 5);
	endtask : s_faults

	task automatic s_pump_off();
		frm(cmd(1'h0, 8'hC3, 1'h0), 64);
		pulse();
		chk("stage", ctl, 8'h41);
		settle();
		chk("final", ctl, 8'hC3);
	endtask : s_pump_off

	task automatic s_midreset();
		@(posedge core_clk);
		#5 srst = 1'h1;
		repeat (2) @(posedge core_clk);
		#5 srst = 1'h0;
		repeat (3) @(posedge core_clk);
		#5;
		s_reset();
	endtask : s_midreset

	task automatic tally_and_finish();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// About 13 frames of 3 us each; generous margin
	initial begin
		#500000;
		mismatches++;
		tally_and_finish();
	end

	initial begin
		srst = 1'h1;
		meas_cycle_start = 1'h0;
		status_word = 64'h0123456789ABCDEF;
		repeat (2) @(posedge core_clk);
		#5 srst = 1'h0;
		repeat (3) @(posedge core_clk);
		#5;
		s_reset();
		s_defer();
		s_echo();
		s_faults();
		s_pump_off();
		s_midreset();
		tally_and_finish();
	end
endmodule : tb
